// File: hdl/dts_map.svh
// register indices, field positions, reset values, trip codes and timing for the drive trip supervisor
`ifndef DTS_MAP_SVH
`define DTS_MAP_SVH

// parameter indices within the protection menu
`define DTS_P_CPU1_WDOG 8'h13
`define DTS_P_CPU2_WDOG 8'h14
`define DTS_P_MOTOR_HOT 8'h15
`define DTS_P_SINK_HOT 8'h16
`define DTS_P_SPD_SAT 8'h17
`define DTS_P_ZERO_DMD 8'h18
`define DTS_P_HIST_0 8'h19
`define DTS_P_HIST_1 8'h1A
`define DTS_P_HIST_2 8'h1B
`define DTS_P_HIST_3 8'h1C
`define DTS_P_DIS_FIELD 8'h1D
`define DTS_P_DIS_FDBK 8'h1E
`define DTS_P_DIS_SUPPLY 8'h1F
`define DTS_P_DIS_MOTOR 8'h20
`define DTS_P_DIS_SINK 8'h21
`define DTS_P_EXT_TRIP 8'h22
`define DTS_P_CPU2_TRIP 8'h23
`define DTS_P_DIS_CLOOP 8'h24
`define DTS_P_DIS_ARM 8'h25

// bit positions in the disable vector
`define DTS_DIS_FIELD 0
`define DTS_DIS_FDBK 1
`define DTS_DIS_SUPPLY 2
`define DTS_DIS_MOTOR 3
`define DTS_DIS_SINK 4
`define DTS_DIS_CLOOP 5
`define DTS_DIS_ARM 6

// bit positions in the synchronised fault vector
`define DTS_F_MOTOR 0
`define DTS_F_SINK 1
`define DTS_F_FIELD 2
`define DTS_F_FDBK 3
`define DTS_F_SUPPLY 4
`define DTS_F_CLOOP 5
`define DTS_F_ARM 6
`define DTS_F_EXT 7

// reset values and the second processor reset command
`define DTS_DIS_RST 7'h08
`define DTS_EXT_RST 1'h0
`define DTS_CPU2_RST 8'h00
`define DTS_HIST_RST 8'h00
`define DTS_CPU2_RESET_CMD 8'hFF

// overload full scale
`define DTS_OVLD_FULL 16'h03E8

// trip codes pushed into the history
`define DTS_CODE_CPU1_WDOG 8'h01
`define DTS_CODE_CPU2_WDOG 8'h02
`define DTS_CODE_OVLD 8'h03
`define DTS_CODE_MOTOR 8'h04
`define DTS_CODE_SINK 8'h05
`define DTS_CODE_FIELD 8'h06
`define DTS_CODE_FDBK 8'h07
`define DTS_CODE_SUPPLY 8'h08
`define DTS_CODE_CLOOP 8'h09
`define DTS_CODE_ARM 8'h0A
`define DTS_CODE_EXT 8'h0B
`define DTS_CODE_CPU2 8'h0C

// timing
`define DTS_CLK_PERIOD_NS 40
`define DTS_TICK_TIME_NS 1000000
`define DTS_WDOG_TIME_NS 1000000

`endif

// File: hdl/dts_pkg.sv
// types shared by the drive trip supervisor
package dts_pkg;

   typedef logic [7:0] dts_code_t;

   typedef struct packed {
      logic [7:0] sy1;
      logic [7:0] sy2;
      logic [7:0] sy3;
      logic [7:0] flt;
      logic [14:0] tick_cnt;
      logic [15:0] rise_cnt;
      logic [15:0] fall_cnt;
      logic [15:0] ovld_acc;
      logic [15:0] wd1_cnt;
      logic [15:0] wd2_cnt;
      logic wd1_flag;
      logic wd2_flag;
      logic sat_flag;
      logic zero_flag;
      logic [3:0][7:0] hist;
      logic [6:0] dis;
      logic ext_req;
      logic [7:0] cpu2_byte;
      logic tripped;
      logic [7:0] rdata;
   } dts_state_s;

endpackage

// File: hdl/dts_supervisor.sv
// drive trip supervisor: overload integrator, watchdogs, fault flags, trip latch and history
`timescale 1ns/1ps
`default_nettype none
`include "dts_map.svh"

module dts_supervisor #(
   parameter int TICK_CYCLES = `DTS_TICK_TIME_NS / `DTS_CLK_PERIOD_NS,
   parameter int WDOG_CYCLES = (`DTS_WDOG_TIME_NS + `DTS_CLK_PERIOD_NS - 1) / `DTS_CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [10:0] current_i,
   input wire logic [10:0] ovld_threshold_i,
   input wire logic [15:0] ovld_rise_rate_i,
   input wire logic [15:0] ovld_fall_rate_i,
   input wire logic cpu1_kick_i,
   input wire logic cpu2_kick_i,
   input wire logic speed_loop_at_limit_i,
   input wire logic current_demand_clamped_i,
   input wire logic motor_therm_trip_i,
   input wire logic heatsink_hot_i,
   input wire logic field_loss_i,
   input wire logic feedback_loss_i,
   input wire logic supply_loss_i,
   input wire logic current_loop_loss_i,
   input wire logic armature_open_circuit_trip_i,
   input wire logic ext_trip_input_i,
   input wire logic [7:0] param_sel_i,
   input wire logic param_wr_i,
   input wire logic [7:0] param_wdata_i,
   input wire logic param_rd_i,
   output logic [7:0] param_rdata_o,
   output logic trip_o,
   output logic [15:0] ovld_acc_o
);

   dts_pkg::dts_state_s s_r;
   dts_pkg::dts_state_s s_nxt;

   logic tick;
   logic above;
   logic below;
   logic [10:0] excess;
   logic [10:0] deficit;
   logic rise_due;
   logic fall_due;
   logic up_step;
   logic dn_step;
   logic [16:0] up_sum;
   logic [15:0] acc_up_val;
   logic [15:0] acc_dn_val;
   logic [11:0] src;
   logic any_src;
   logic reset_cmd;
   logic new_trip;
   dts_pkg::dts_code_t code;

   ////////////////////////////////////////////////////////////////////////////////
   // overload integrator arithmetic

   assign tick = (s_r.tick_cnt == 15'(TICK_CYCLES - 1));
   assign above = (current_i > ovld_threshold_i);
   assign below = (current_i < ovld_threshold_i);
   assign excess = current_i - ovld_threshold_i;
   assign deficit = ovld_threshold_i - current_i;
   // a rate of zero behaves as one tick, so the integrator never stalls
   assign rise_due = ({1'b0, s_r.rise_cnt} + 17'h00001) >= {1'b0, ovld_rise_rate_i};
   assign fall_due = ({1'b0, s_r.fall_cnt} + 17'h00001) >= {1'b0, ovld_fall_rate_i};
   assign up_step = tick && above && rise_due;
   assign dn_step = tick && below && fall_due;
   assign up_sum = {1'b0, s_r.ovld_acc} + {6'h00, excess};
   // saturate rather than wrap: a wrapped accumulator would clear a pending overload
   assign acc_up_val = up_sum[16] ? 16'hFFFF : up_sum[15:0];
   assign acc_dn_val = (s_r.ovld_acc > {5'h00, deficit}) ? (s_r.ovld_acc - {5'h00, deficit}) : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // trip sources; the seven fault inputs other than the external trip are each gated by a disable bit

   assign reset_cmd = param_wr_i && (param_sel_i == `DTS_P_CPU2_TRIP) && (param_wdata_i == `DTS_CPU2_RESET_CMD);

   always_comb begin
      src = 12'h000;
      // a reset command masks a flag that it clears, else the latch would re-trip on the stale flag
      src[0] = s_r.wd1_flag && !(reset_cmd && !(s_r.wd1_cnt == 16'(WDOG_CYCLES - 1) && !cpu1_kick_i));
      src[1] = s_r.wd2_flag && !(reset_cmd && !(s_r.wd2_cnt == 16'(WDOG_CYCLES - 1) && !cpu2_kick_i));
      src[2] = (s_r.ovld_acc >= `DTS_OVLD_FULL);
      src[3] = s_r.flt[`DTS_F_MOTOR] && !s_r.dis[`DTS_DIS_MOTOR];
      src[4] = s_r.flt[`DTS_F_SINK] && !s_r.dis[`DTS_DIS_SINK];
      src[5] = s_r.flt[`DTS_F_FIELD] && !s_r.dis[`DTS_DIS_FIELD];
      src[6] = s_r.flt[`DTS_F_FDBK] && !s_r.dis[`DTS_DIS_FDBK];
      src[7] = s_r.flt[`DTS_F_SUPPLY] && !s_r.dis[`DTS_DIS_SUPPLY];
      src[8] = s_r.flt[`DTS_F_CLOOP] && !s_r.dis[`DTS_DIS_CLOOP];
      src[9] = s_r.flt[`DTS_F_ARM] && !s_r.dis[`DTS_DIS_ARM];
      src[10] = s_r.ext_req || s_r.flt[`DTS_F_EXT];
      src[11] = (s_r.cpu2_byte != 8'h00) && !reset_cmd;
   end

   assign any_src = |src;
   // a source present in the reset cycle re-trips at once and is recorded again
   assign new_trip = any_src && (!s_r.tripped || reset_cmd);

   // lowest index wins when several sources fire together
   always_comb begin
      code = 8'h00;
      if (src[0]) begin
         code = `DTS_CODE_CPU1_WDOG;
      end else if (src[1]) begin
         code = `DTS_CODE_CPU2_WDOG;
      end else if (src[2]) begin
         code = `DTS_CODE_OVLD;
      end else if (src[3]) begin
         code = `DTS_CODE_MOTOR;
      end else if (src[4]) begin
         code = `DTS_CODE_SINK;
      end else if (src[5]) begin
         code = `DTS_CODE_FIELD;
      end else if (src[6]) begin
         code = `DTS_CODE_FDBK;
      end else if (src[7]) begin
         code = `DTS_CODE_SUPPLY;
      end else if (src[8]) begin
         code = `DTS_CODE_CLOOP;
      end else if (src[9]) begin
         code = `DTS_CODE_ARM;
      end else if (src[10]) begin
         code = `DTS_CODE_EXT;
      end else if (src[11]) begin
         code = `DTS_CODE_CPU2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt = s_r;
      // three-stage sync; a pin change counts once stages two and three agree
      s_nxt.sy1 = {ext_trip_input_i, armature_open_circuit_trip_i, current_loop_loss_i, supply_loss_i,
                   feedback_loss_i, field_loss_i, heatsink_hot_i, motor_therm_trip_i};
      s_nxt.sy2 = s_r.sy1;
      s_nxt.sy3 = s_r.sy2;
      s_nxt.flt = (s_r.sy2 & s_r.sy3) | (s_r.flt & (s_r.sy2 | s_r.sy3));
      s_nxt.sat_flag = speed_loop_at_limit_i;
      s_nxt.zero_flag = current_demand_clamped_i;

      // overload integrator
      s_nxt.tick_cnt = tick ? 15'h0000 : s_r.tick_cnt + 15'h0001;
      if (tick) begin
         if (above) begin
            s_nxt.fall_cnt = 16'h0000;
            s_nxt.rise_cnt = rise_due ? 16'h0000 : s_r.rise_cnt + 16'h0001;
         end else if (below) begin
            s_nxt.rise_cnt = 16'h0000;
            s_nxt.fall_cnt = fall_due ? 16'h0000 : s_r.fall_cnt + 16'h0001;
         end
      end
      if (up_step) begin
         s_nxt.ovld_acc = acc_up_val;
      end else if (dn_step) begin
         s_nxt.ovld_acc = acc_dn_val;
      end

      // watchdogs: a restart pulse reloads the count, expiry latches the flag
      if (cpu1_kick_i) begin
         s_nxt.wd1_cnt = 16'h0000;
      end else if (s_r.wd1_cnt == 16'(WDOG_CYCLES - 1)) begin
         s_nxt.wd1_flag = 1'b1;
      end else begin
         s_nxt.wd1_cnt = s_r.wd1_cnt + 16'h0001;
      end
      if (cpu2_kick_i) begin
         s_nxt.wd2_cnt = 16'h0000;
      end else if (s_r.wd2_cnt == 16'(WDOG_CYCLES - 1)) begin
         s_nxt.wd2_flag = 1'b1;
      end else begin
         s_nxt.wd2_cnt = s_r.wd2_cnt + 16'h0001;
      end

      // register writes; read-only indices ignore writes
      if (param_wr_i) begin
         if (param_sel_i == `DTS_P_DIS_FIELD) begin
            s_nxt.dis[`DTS_DIS_FIELD] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_DIS_FDBK) begin
            s_nxt.dis[`DTS_DIS_FDBK] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_DIS_SUPPLY) begin
            s_nxt.dis[`DTS_DIS_SUPPLY] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_DIS_MOTOR) begin
            s_nxt.dis[`DTS_DIS_MOTOR] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_DIS_SINK) begin
            s_nxt.dis[`DTS_DIS_SINK] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_EXT_TRIP) begin
            s_nxt.ext_req = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_CPU2_TRIP) begin
            // 255 is a reset command, so the byte returns to its healthy zero
            s_nxt.cpu2_byte = reset_cmd ? `DTS_CPU2_RST : param_wdata_i;
         end else if (param_sel_i == `DTS_P_DIS_CLOOP) begin
            s_nxt.dis[`DTS_DIS_CLOOP] = param_wdata_i[0];
         end else if (param_sel_i == `DTS_P_DIS_ARM) begin
            s_nxt.dis[`DTS_DIS_ARM] = param_wdata_i[0];
         end
      end

      // reset command clears watchdog flags; an expiry in the same cycle wins
      if (reset_cmd) begin
         if (!(s_r.wd1_cnt == 16'(WDOG_CYCLES - 1) && !cpu1_kick_i)) begin
            s_nxt.wd1_flag = 1'b0;
         end
         if (!(s_r.wd2_cnt == 16'(WDOG_CYCLES - 1) && !cpu2_kick_i)) begin
            s_nxt.wd2_flag = 1'b0;
         end
         s_nxt.wd1_cnt = 16'h0000;
         s_nxt.wd2_cnt = 16'h0000;
      end

      // trip latch and history
      s_nxt.tripped = any_src || (s_r.tripped && !reset_cmd);
      if (new_trip) begin
         s_nxt.hist = {s_r.hist[2:0], code};
      end

      // registered read port; unmapped indices read zero
      if (param_rd_i) begin
         if (param_sel_i == `DTS_P_CPU1_WDOG) begin
            s_nxt.rdata = {7'h00, s_r.wd1_flag};
         end else if (param_sel_i == `DTS_P_CPU2_WDOG) begin
            s_nxt.rdata = {7'h00, s_r.wd2_flag};
         end else if (param_sel_i == `DTS_P_MOTOR_HOT) begin
            s_nxt.rdata = {7'h00, s_r.flt[`DTS_F_MOTOR]};
         end else if (param_sel_i == `DTS_P_SINK_HOT) begin
            s_nxt.rdata = {7'h00, s_r.flt[`DTS_F_SINK]};
         end else if (param_sel_i == `DTS_P_SPD_SAT) begin
            s_nxt.rdata = {7'h00, s_r.sat_flag};
         end else if (param_sel_i == `DTS_P_ZERO_DMD) begin
            s_nxt.rdata = {7'h00, s_r.zero_flag};
         end else if (param_sel_i == `DTS_P_HIST_0) begin
            s_nxt.rdata = s_r.hist[0];
         end else if (param_sel_i == `DTS_P_HIST_1) begin
            s_nxt.rdata = s_r.hist[1];
         end else if (param_sel_i == `DTS_P_HIST_2) begin
            s_nxt.rdata = s_r.hist[2];
         end else if (param_sel_i == `DTS_P_HIST_3) begin
            s_nxt.rdata = s_r.hist[3];
         end else if (param_sel_i == `DTS_P_DIS_FIELD) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_FIELD]};
         end else if (param_sel_i == `DTS_P_DIS_FDBK) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_FDBK]};
         end else if (param_sel_i == `DTS_P_DIS_SUPPLY) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_SUPPLY]};
         end else if (param_sel_i == `DTS_P_DIS_MOTOR) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_MOTOR]};
         end else if (param_sel_i == `DTS_P_DIS_SINK) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_SINK]};
         end else if (param_sel_i == `DTS_P_EXT_TRIP) begin
            s_nxt.rdata = {7'h00, s_r.ext_req};
         end else if (param_sel_i == `DTS_P_CPU2_TRIP) begin
            s_nxt.rdata = s_r.cpu2_byte;
         end else if (param_sel_i == `DTS_P_DIS_CLOOP) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_CLOOP]};
         end else if (param_sel_i == `DTS_P_DIS_ARM) begin
            s_nxt.rdata = {7'h00, s_r.dis[`DTS_DIS_ARM]};
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register; the clock enable freezes everything

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
         s_r.dis <= `DTS_DIS_RST;
         s_r.ext_req <= `DTS_EXT_RST;
         s_r.cpu2_byte <= `DTS_CPU2_RST;
         s_r.hist <= {4{`DTS_HIST_RST}};
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign param_rdata_o = s_r.rdata;
   assign trip_o = s_r.tripped;
   assign ovld_acc_o = s_r.ovld_acc;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   chk_ovld_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && up_step |=> s_r.ovld_acc == $past(acc_up_val) && s_r.ovld_acc >= $past(s_r.ovld_acc))
      else $error("overload accumulator did not rise by the excess");

   chk_ovld_floor: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && below |=> s_r.ovld_acc <= $past(s_r.ovld_acc) && (($past(s_r.ovld_acc) == 16'h0000) -> s_r.ovld_acc == 16'h0000))
      else $error("overload accumulator rose or left zero below threshold");

   chk_ovld_rate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && tick && above && !rise_due |=> s_r.ovld_acc == $past(s_r.ovld_acc))
      else $error("overload accumulator moved before its rate count elapsed");

   chk_wdog_expiry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && !cpu1_kick_i && s_r.wd1_cnt == 16'(WDOG_CYCLES - 1) ##1 ce_i |=> s_r.wd1_flag && s_r.tripped)
      else $error("first watchdog expiry did not flag and trip");

   chk_motor_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && param_rd_i && param_sel_i == `DTS_P_MOTOR_HOT |=> s_r.rdata == {7'h00, $past(s_r.flt[`DTS_F_MOTOR])})
      else $error("motor overtemperature flag read back wrong");

   chk_hist_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !(ce_i && new_trip) |=> $stable(s_r.hist))
      else $error("trip history changed without a new trip");

   chk_hist_shift: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && new_trip |=> s_r.hist[0] == $past(code) && s_r.hist[1] == $past(s_r.hist[0])
         && s_r.hist[3] == $past(s_r.hist[2]))
      else $error("trip history did not shift on a new trip");

   chk_cpu2_trip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && param_wr_i && param_sel_i == `DTS_P_CPU2_TRIP && param_wdata_i != 8'h00
         && param_wdata_i != `DTS_CPU2_RESET_CMD ##1 ce_i |=> s_r.tripped)
      else $error("second processor trip byte did not trip");

   chk_cpu2_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && reset_cmd && !any_src |=> !s_r.tripped && s_r.cpu2_byte == 8'h00)
      else $error("reset command left the trip latched");

   chk_trip_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_r.tripped && !(ce_i && reset_cmd) |=> s_r.tripped)
      else $error("trip released without a reset command");

endmodule

`default_nettype wire

// File: tb/dts_cpu_model.sv
// processor model: restarts both watchdogs on a fixed period while running
`timescale 1ns/1ps
`default_nettype none
module dts_cpu_model #(
   parameter int KICK_PERIOD = 10
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [1:0] run_i,
   output logic cpu1_kick_o,
   output logic cpu2_kick_o
);
   int cnt;
   // kick well inside the timeout so a slow edge never trips
   always @(negedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= 0;
         cpu1_kick_o <= 1'b0;
         cpu2_kick_o <= 1'b0;
      end else begin
         cnt <= (cnt == KICK_PERIOD - 1) ? 0 : cnt + 1;
         cpu1_kick_o <= run_i[0] && (cnt == KICK_PERIOD - 1);
         cpu2_kick_o <= run_i[1] && (cnt == KICK_PERIOD - 1);
      end
   end
endmodule
`default_nettype wire

// File: tb/dts_supervisor_test.sv
// self-checking bench for the drive trip supervisor
`timescale 1ns/1ps
`default_nettype none
module dts_supervisor_test;
   localparam int WDOG = 40;
   typedef struct packed {logic [7:0] sel; logic wr; logic [7:0] wd; logic [7:0] exp;} dts_row_s;
   logic clk = 1'b0, rst_b = 1'b0, spd = 1'b0, clamp = 1'b0, wr = 1'b0, rd = 1'b0, trip;
   logic [10:0] cur = 11'h000, thr = 11'h064;
   logic [15:0] rise = 16'h0002, fall = 16'h0001, acc;
   logic [7:0] flt = 8'h00, sel = 8'h00, wd = 8'h00, rdata;
   logic [1:0] run = 2'h3;
   logic k1, k2;
   int err_total = 0, cmp_count = 0;
   dts_row_s rows [0:15] = '{'{8'h1D,0,0,0}, '{8'h1E,0,0,0}, '{8'h1F,0,0,0}, '{8'h20,0,0,1}, '{8'h21,0,0,0},
      '{8'h22,0,0,0}, '{8'h23,0,0,0}, '{8'h24,0,0,0}, '{8'h25,0,0,0}, '{8'h19,0,0,0}, '{8'h13,0,0,0},
      '{8'h14,0,0,0}, '{8'h19,1,8'hFF,0}, '{8'h40,1,8'h05,0}, '{8'h21,1,8'h01,1}, '{8'h21,1,8'h00,0}};
   logic [7:0] src_dis [0:7] = '{8'h20, 8'h21, 8'h1D, 8'h1E, 8'h1F, 8'h24, 8'h25, 8'h00};
   logic [7:0] src_code [0:7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B};
   logic [7:0] src_flag [0:7] = '{8'h15, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   dts_supervisor #(.TICK_CYCLES(4), .WDOG_CYCLES(WDOG)) dts_supervisor_i (.clk_i(clk), .rst_b_i(rst_b),
      .ce_i(1'b1), .current_i(cur), .ovld_threshold_i(thr), .ovld_rise_rate_i(rise), .ovld_fall_rate_i(fall),
      .cpu1_kick_i(k1), .cpu2_kick_i(k2), .speed_loop_at_limit_i(spd), .current_demand_clamped_i(clamp),
      .motor_therm_trip_i(flt[0]), .heatsink_hot_i(flt[1]), .field_loss_i(flt[2]), .feedback_loss_i(flt[3]),
      .supply_loss_i(flt[4]), .current_loop_loss_i(flt[5]), .armature_open_circuit_trip_i(flt[6]),
      .ext_trip_input_i(flt[7]), .param_sel_i(sel), .param_wr_i(wr), .param_wdata_i(wd), .param_rd_i(rd),
      .param_rdata_o(rdata), .trip_o(trip), .ovld_acc_o(acc));
   dts_cpu_model dts_cpu_model_i (.clk_i(clk), .rst_b_i(rst_b), .run_i(run), .cpu1_kick_o(k1), .cpu2_kick_o(k2));

   initial begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s exp %b got %b", name, exp, got);
      end
   endtask
   task automatic chk_acc(input logic [15:0] exp);
      cmp_count++;
      if (acc !== exp) begin
         err_total++;
         $display("[ERR] overload acc exp %h got %h", exp, acc);
      end
   endtask
   task automatic wr_reg(input logic [7:0] s, input logic [7:0] d);
      sel = s;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] s, input logic [7:0] exp);
      sel = s;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      cmp_count++;
      if (rdata !== exp) begin
         err_total++;
         $display("[ERR] param %h exp %h got %h", s, exp, rdata);
      end
   endtask
   task automatic clear_trip;
      wr_reg(8'h23, 8'hFF);
      @(negedge clk);
      chk_bit("trip cleared", 1'b0, trip);
   endtask
   // generous span: the whole sequence needs only a few hundred cycles
   initial begin
      #(40 * 20000);
      err_total++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      foreach (rows[i]) begin
         if (rows[i].wr) wr_reg(rows[i].sel, rows[i].wd);
         chk_reg(rows[i].sel, rows[i].exp);
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         if (src_dis[i] != 8'h00) wr_reg(src_dis[i], 8'h01);
         flt[i] = 1'b1;
         repeat (10) @(negedge clk);
         if (src_dis[i] != 8'h00) begin
            chk_bit("disabled source", 1'b0, trip);
            wr_reg(src_dis[i], 8'h00);
            repeat (3) @(negedge clk);
         end
         if (src_flag[i] != 8'h00) chk_reg(src_flag[i], 8'h01);
         chk_bit("source trip", 1'b1, trip);
         chk_reg(8'h19, src_code[i]);
         flt[i] = 1'b0;
         repeat (10) @(negedge clk);
         if (src_flag[i] != 8'h00) chk_reg(src_flag[i], 8'h00);
         clear_trip();
      end
      chk_reg(8'h19, 8'h0B);
      chk_reg(8'h1A, 8'h0A);
      chk_reg(8'h1B, 8'h09);
      chk_reg(8'h1C, 8'h08);
      $display("test sources done");
      spd = 1'b1;
      clamp = 1'b1;
      repeat (2) @(negedge clk);
      chk_reg(8'h17, 8'h01);
      chk_reg(8'h18, 8'h01);
      spd = 1'b0;
      clamp = 1'b0;
      repeat (2) @(negedge clk);
      chk_reg(8'h17, 8'h00);
      chk_reg(8'h18, 8'h00);
      chk_reg(8'h1C, 8'h08);
      $display("test flags done");
      for (int w = 0; w < 2; w++) begin
         run[w] = 1'b0;
         repeat (WDOG + 10) @(negedge clk);
         chk_reg(w == 0 ? 8'h13 : 8'h14, 8'h01);
         chk_bit("watchdog trip", 1'b1, trip);
         chk_reg(8'h19, w == 0 ? 8'h01 : 8'h02);
         run[w] = 1'b1;
         repeat (15) @(negedge clk);
         clear_trip();
         chk_reg(w == 0 ? 8'h13 : 8'h14, 8'h00);
      end
      $display("test watchdogs done");
      wr_reg(8'h23, 8'h05);
      repeat (2) @(negedge clk);
      chk_bit("cpu2 trip", 1'b1, trip);
      chk_reg(8'h19, 8'h0C);
      chk_reg(8'h23, 8'h05);
      clear_trip();
      chk_reg(8'h23, 8'h00);
      $display("test cpu2 byte done");
      cur = 11'h258;
      for (int k = 0; k < 300 && acc === 16'h0000; k++) @(negedge clk);
      chk_acc(16'h01F4);
      for (int k = 0; k < 300 && trip !== 1'b1; k++) @(negedge clk);
      chk_reg(8'h19, 8'h03);
      cur = 11'h000;
      for (int k = 0; k < 600 && acc !== 16'h0000; k++) @(negedge clk);
      chk_acc(16'h0000);
      repeat (20) @(negedge clk);
      chk_acc(16'h0000);
      clear_trip();
      $display("test overload done");
      wr_reg(8'h22, 8'h01);
      repeat (2) @(negedge clk);
      chk_bit("ext trip", 1'b1, trip);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("trip in reset", 1'b0, trip);
      rst_b = 1'b1;
      @(negedge clk);
      chk_reg(8'h22, 8'h00);
      chk_reg(8'h20, 8'h01);
      chk_reg(8'h19, 8'h00);
      $display("test reset done");
      stop_test();
   end
endmodule
`default_nettype wire
